// ---- rtl/asmc_ctrl.sv ----
// host controller that drives an asynchronous 128k x 8 sram
`timescale 1ns/1ps
`default_nettype none
module asmc_ctrl #(
	parameter int NUM_CHIPS = 1
) (
	input wire logic i_mclk, // 250 mhz clock
	input wire logic i_resetn, // async reset, active low
	input wire logic i_req, // request pulse, taken when o_ready high
	input wire logic i_we, // 1 write, 0 read
	input wire logic [$clog2(NUM_CHIPS+1)-1:0] i_chip, // chip index
	input wire logic [asmc_pkg::ADDR_W-1:0] i_addr, // byte address
	input wire logic [asmc_pkg::DATA_W-1:0] i_wdata, // write byte
	output logic o_ready, // idle, may take a request
	output logic o_rvalid, // read data valid pulse
	output logic [asmc_pkg::DATA_W-1:0] o_rdata, // read byte
	output logic [asmc_pkg::ADDR_W-1:0] o_mem_addr, // sram address pins
	output logic [NUM_CHIPS-1:0] o_select_low_active_n, // active-low selects
	output logic [NUM_CHIPS-1:0] o_select_high_active, // active-high selects
	output logic o_write_n, // write strobe, active low
	output logic o_oe_n, // output enable, active low
	input wire logic [asmc_pkg::DATA_W-1:0] i_dq, // data pins in
	output logic [asmc_pkg::DATA_W-1:0] o_dq, // data pins out
	output logic o_dq_oe // high while host drives data
);
	// refused at elaboration: the index width and the select loop serve 1 to 16 chips
	if (NUM_CHIPS < 1 || NUM_CHIPS > 16) begin : g_bad_chips
		$error("asmc_ctrl: NUM_CHIPS out of range");
	end

	asmc_pkg::asmc_state_t state_q;
	logic [asmc_pkg::CNT_W-1:0] cnt_q;
	logic [NUM_CHIPS-1:0] sel_q;
	logic [NUM_CHIPS-1:0] pick; // select pattern for the requested index
	logic take; // request accepted at this edge
	logic [asmc_pkg::CNT_W-1:0] wlen_q; // strobe cycles so far, for the width check

	// one-hot select for the chosen chip, at most one chip ever enabled
	function automatic logic [NUM_CHIPS-1:0] onehot(input logic [$clog2(NUM_CHIPS+1)-1:0] idx);
		logic [NUM_CHIPS-1:0] v;
		v = '0;
		for (int k = 0; k < NUM_CHIPS; k++) begin
			if (idx == k[$clog2(NUM_CHIPS+1)-1:0]) v[k] = 1'b1;
		end
		return v;
	endfunction : onehot

	function automatic logic [asmc_pkg::CNT_W-1:0] cyc(input int n);
		return asmc_pkg::CNT_W'(n - 1);
	endfunction : cyc

	// an index with no chip behind it is refused, so no strobe ever runs unselected
	assign pick = onehot(i_chip);
	assign take = state_q == asmc_pkg::ASMC_IDLE && i_req && pick != '0; // RQ8

	// sequencer: write is setup, strobe pulse, hold; read waits access time
	// each phase loads its length less one and leaves when the count reaches zero,
	// so a phase of n cycles spans n edges and the registered pins follow one edge later
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= asmc_pkg::ASMC_IDLE;
			cnt_q <= 8'h00;
			sel_q <= '0;
		end else begin
			case (state_q)
				asmc_pkg::ASMC_IDLE: begin
					sel_q <= '0;
					if (take) begin
						sel_q <= pick; // RQ8
						cnt_q <= i_we ? cyc(asmc_pkg::SETUP_CYC) : cyc(asmc_pkg::READ_CYC);
						state_q <= i_we ? asmc_pkg::ASMC_WSETUP : asmc_pkg::ASMC_RWAIT;
					end
				end
				asmc_pkg::ASMC_WSETUP: begin
					if (cnt_q == 8'h00) begin
						cnt_q <= cyc(asmc_pkg::WRITE_CYC);
						state_q <= asmc_pkg::ASMC_WPULSE;
					end else cnt_q <= cnt_q - 8'h01;
				end
				asmc_pkg::ASMC_WPULSE: begin
					if (cnt_q == 8'h00) begin
						cnt_q <= cyc(asmc_pkg::HOLD_CYC);
						state_q <= asmc_pkg::ASMC_WHOLD;
					end else cnt_q <= cnt_q - 8'h01;
				end
				asmc_pkg::ASMC_WHOLD: begin
					if (cnt_q == 8'h00) begin
						sel_q <= '0;
						state_q <= asmc_pkg::ASMC_IDLE;
					end else cnt_q <= cnt_q - 8'h01;
				end
				asmc_pkg::ASMC_RWAIT: begin
					if (cnt_q == 8'h00) begin
						sel_q <= '0;
						state_q <= asmc_pkg::ASMC_IDLE;
					end else cnt_q <= cnt_q - 8'h01;
				end
				default: state_q <= asmc_pkg::ASMC_IDLE;
			endcase
		end
	end

	// address and write data latched at request and held to the end
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_mem_addr <= '0;
			o_dq <= 8'h00;
		end else if (take) begin
			o_mem_addr <= i_addr; // RQ3
			o_dq <= i_wdata;
		end
	end

	// pin controls registered; select stays on through setup and hold
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_select_low_active_n <= '1;
			o_select_high_active <= '0;
			o_write_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_dq_oe <= 1'b0;
			o_ready <= 1'b0;
		end else begin
			o_select_low_active_n <= ~sel_q; // RQ7
			o_select_high_active <= sel_q; // RQ2
			// strobe falls only after setup and rises before hold ends the select
			o_write_n <= ~(state_q == asmc_pkg::ASMC_WPULSE); // RQ2 RQ9
			o_oe_n <= ~(state_q == asmc_pkg::ASMC_RWAIT); // RQ6
			// host drives data only while sram outputs are off (enable high)
			o_dq_oe <= state_q inside {asmc_pkg::ASMC_WSETUP, asmc_pkg::ASMC_WPULSE,
				asmc_pkg::ASMC_WHOLD}; // RQ4 RQ5
			o_ready <= state_q == asmc_pkg::ASMC_IDLE && !take;
		end
	end

	// read byte sampled on the last cycle of the access wait
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rvalid <= 1'b0;
			o_rdata <= 8'h00;
		end else begin
			o_rvalid <= 1'b0;
			if (state_q == asmc_pkg::ASMC_RWAIT && cnt_q == 8'h00) begin
				o_rvalid <= 1'b1;
				o_rdata <= i_dq; // RQ1
			end
		end
	end

	// counts the cycles for which the strobe has been low; a plain repetition
	// cannot reach the full pulse width, so the width is checked on this count
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			wlen_q <= 8'h00;
		end else if (!o_write_n) begin
			wlen_q <= wlen_q + 8'h01;
		end else begin
			wlen_q <= 8'h00;
		end
	end

	// the strobe never meets an enabled sram or an undriven bus
	a_wr_oe_off: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ5
		!o_write_n |-> o_oe_n && o_dq_oe)
		else $error("strobe low with enable low or bus undriven");

	// both select polarities agree and name at most one chip
	a_one_chip: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ8
		$onehot0(o_select_high_active) && (o_select_high_active == ~o_select_low_active_n))
		else $error("more than one chip selected");

	// a strobe on a deselected bus would be wasted and hides a sequencing fault
	a_wr_selected: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ2
		!o_write_n |-> o_select_high_active != '0)
		else $error("write strobe while deselected");

	// address and data stay put for as long as the host drives the bus
	a_addr_stable: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ3
		o_dq_oe && $past(o_dq_oe) |-> $stable(o_mem_addr) && $stable(o_dq))
		else $error("address or data moved during write");

	// the strobe ends the write, so select and data outlast its rise
	a_wr_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ4
		$rose(o_write_n) && o_dq_oe |-> o_select_high_active != '0 ##1 o_dq_oe)
		else $error("select or data lost at strobe rise");

	// output enable only with the chip selected and the host off the bus
	a_rd_enable: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ6
		!o_oe_n |-> o_write_n && !o_dq_oe && o_select_high_active != '0)
		else $error("read enable without select or with bus driven");

	// every read that opens the outputs hands a byte back
	a_rd_done: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ6
		$fell(o_oe_n) |-> ##[1:30] o_rvalid)
		else $error("read never completed");

	// the first part of the strobe pulse, as far as a repetition may reach
	a_wr_len: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ4
		$fell(o_write_n) |-> !o_write_n [*8])
		else $error("write pulse too short");

	// the bus was driven and the address set up before the strobe fell
	a_wr_setup: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ3
		$fell(o_write_n) |-> $past(o_dq_oe, 3))
		else $error("strobe fell without address and data setup");

	// the whole strobe pulse lasts the write time in cycles
	a_wr_width: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ4
		$rose(o_write_n) |-> wlen_q == asmc_pkg::CNT_W'(asmc_pkg::WRITE_CYC))
		else $error("write pulse width wrong");

	// select and data stay on for the hold time after the strobe rises
	a_wr_hold_len: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ4
		$rose(o_write_n) |-> (o_dq_oe && o_select_high_active != '0) [*3])
		else $error("hold after strobe too short");

	// read data valid is a single-cycle pulse
	a_rd_pulse: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ6
		o_rvalid |=> !o_rvalid)
		else $error("read valid longer than one cycle");

	// with no chip selected the strobe, the enable and the host drivers all rest
	a_idle_quiet: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ7
		o_select_high_active == '0 |-> o_write_n && o_oe_n && !o_dq_oe)
		else $error("control active while deselected");

	// a request for an index without a chip is refused and the block stays idle
	a_bad_chip: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RQ8
		o_ready && i_req && pick == '0 |=> o_ready && o_select_high_active == '0)
		else $error("request for absent chip taken");
endmodule : asmc_ctrl
`default_nettype wire

// ---- rtl/asmc_pkg.sv ----
// package of constants for the asynchronous sram host controller
// Notes on behaviour
// RQ1 - memory has 131072 byte locations, 17-bit address, shared 8-bit data path
// RQ2 - write happens only while strobe low, low select low, high select high
// RQ3 - host sets address before write interval and holds it throughout
// RQ4 - data captured at first ending edge; host holds data valid around it
// RQ5 - output enable high keeps sram drivers off so host can drive data
// RQ6 - sram drives stored byte when strobe high, enable low, selected
// RQ7 - deselected sram refuses reads and writes and floats its data pins
// RQ8 - with shared bus, host enables at most one sram at a time
// RQ9 - selected with strobe low writes regardless of enable; both high floats
package asmc_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_PS = 4000;
	// access and phase times in ps, slowest speed grade by default
	localparam int T_SETUP_PS = 10000;
	localparam int T_WRITE_PS = 55000;
	localparam int T_HOLD_PS = 10000;
	localparam int T_READ_PS = 70000;
	// least times round up to whole cycles
	localparam int SETUP_CYC = (T_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WRITE_CYC = (T_WRITE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int HOLD_CYC = (T_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int READ_CYC = (T_READ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 8;
	typedef enum logic [2:0] {
		ASMC_IDLE = 3'b000,
		ASMC_WSETUP = 3'b001,
		ASMC_WPULSE = 3'b010,
		ASMC_WHOLD = 3'b011,
		ASMC_RWAIT = 3'b100
	} asmc_state_t;
endpackage : asmc_pkg

// ---- sim/asmc_ctrl_test.sv ----
// self-checking bench for the sram host controller
`timescale 1ns/1ps
`default_nettype none
module asmc_ctrl_test;
	logic clk = 1'b0, rstn = 1'b0, req = 1'b0, we = 1'b0;
	logic [16:0] addr = '0, maddr, wa;
	logic [7:0] wdata = '0, rdata, hdq, sdq, bus;
	logic [0:0] seln, sel;
	logic [0:0] chip = 1'b0;
	logic ready, rvalid, wn, oen, dq_oe, drv;
	int checks = 0, fail_count = 0;
	// rows: write flag, address, write byte, expected read byte
	logic [33:0] rows [7] = '{{1'b1, 17'h00000, 8'ha5, 8'h00}, {1'b1, 17'h1ffff, 8'h5a, 8'h00},
		{1'b0, 17'h00000, 8'h00, 8'ha5}, {1'b0, 17'h1ffff, 8'h00, 8'h5a}, {1'b1, 17'h00000, 8'h3c, 8'h00},
		{1'b1, 17'h00005, 8'h11, 8'h00}, {1'b0, 17'h00000, 8'h00, 8'h3c}};
	asmc_ctrl dut (.i_mclk(clk), .i_resetn(rstn), .i_req(req), .i_we(we), .i_chip(chip), .i_addr(addr),
		.i_wdata(wdata), .o_ready(ready), .o_rvalid(rvalid), .o_rdata(rdata), .o_mem_addr(maddr),
		.o_select_low_active_n(seln), .o_select_high_active(sel), .o_write_n(wn), .o_oe_n(oen),
		.i_dq(bus), .o_dq(hdq), .o_dq_oe(dq_oe));
	asmc_sram_model ram (.i_sel_n(seln[0]), .i_sel(sel[0]), .i_write_n(wn), .i_oe_n(oen), .i_addr(maddr),
		.i_dq(bus), .o_drive(drv), .o_dq(sdq));
	// nobody driving leaves the inverse of the host byte
	assign bus = dq_oe ? hdq : drv ? sdq : ~hdq;
	initial forever #2 clk = ~clk;
	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test
	// one transfer; a read is waited for and compared
	task automatic op(input logic w, input logic [16:0] a, input logic [7:0] d, input logic [7:0] e);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk(ready === 1'b1, "request never accepted");
		we = w;
		addr = a;
		wdata = d;
		req = 1'b1;
		@(negedge clk) req = 1'b0;
		n = 0;
		while (!w && rvalid !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (!w) begin
			chk(rdata === e && n == asmc_pkg::READ_CYC, "read byte or latency");
			@(negedge clk);
			chk(rvalid === 1'b0 && oen === 1'b1, "read pulse or enable stuck");
		end
	endtask : op
	// both drivers on the wire at once is contention
	always @(negedge clk) if (dq_oe && drv) chk(1'b0, "bus contention");
	always @(negedge wn) wa = maddr;
	always @(posedge wn) if (rstn) chk(maddr === wa, "address moved in write");
	initial begin
		repeat (5) @(negedge clk);
		chk(seln === 1'b1 && sel === 1'b0 && wn === 1'b1 && oen === 1'b1 && dq_oe === 1'b0, "reset pins");
		rstn = 1'b1;
		foreach (rows[i]) op(rows[i][33], rows[i][32:16], rows[i][15:8], rows[i][7:0]);
		$display("test rows done");
		// an index with no chip behind it: nothing selected, and the byte never lands
		chip = 1'b1;
		op(1'b1, 17'h00005, 8'h99, 8'h00);
		repeat (3) @(negedge clk);
		chk(sel === 1'b0 && seln === 1'b1 && wn === 1'b1 && ready === 1'b1, "absent chip selected");
		chip = 1'b0;
		$display("test chip done");
		op(1'b1, 17'h00005, 8'h77, 8'h00);
		@(negedge clk) rstn = 1'b0;
		@(negedge clk) chk(seln === 1'b1 && wn === 1'b1 && dq_oe === 1'b0, "abort pins");
		rstn = 1'b1;
		op(1'b0, 17'h00005, 8'h00, 8'h11);
		$display("test abort done");
		end_of_test();
	end
	// watchdog: the whole run needs about 180 cycles
	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		end_of_test();
	end
endmodule : asmc_ctrl_test
`default_nettype wire

// ---- sim/asmc_sram_model.sv ----
// behavioural model of the 128k x 8 static ram on the far side
`timescale 1ns/1ps
`default_nettype none
module asmc_sram_model (
	input wire logic i_sel_n, // low-active select
	input wire logic i_sel, // high-active select
	input wire logic i_write_n, // write strobe, active low
	input wire logic i_oe_n, // output enable, active low
	input wire logic [asmc_pkg::ADDR_W-1:0] i_addr, // address pins
	input wire logic [asmc_pkg::DATA_W-1:0] i_dq, // resolved data wire
	output logic o_drive, // high while the ram drives data
	output logic [asmc_pkg::DATA_W-1:0] o_dq // data driven by the ram
);
	logic [7:0] mem [0:131071];
	logic [7:0] last = 8'h00;
	logic wr;
	logic wr_was = 1'b0;
	// write window is the overlap of strobe and both selects
	assign wr = !i_sel_n && i_sel && !i_write_n;
	// capture on whichever edge closes the window first; leaving an unknown level is no write
	always @(wr) begin
		if (wr_was && wr === 1'b0) mem[i_addr] = i_dq;
		wr_was = wr === 1'b1;
	end
	// drivers off unless selected, reading and enabled
	assign o_drive = !i_sel_n && i_sel && i_write_n && !i_oe_n;
	always @(o_drive or i_addr) if (o_drive) last = mem[i_addr];
	// a released wire shows the inverse, never a stale byte
	assign o_dq = o_drive ? mem[i_addr] : ~last;
endmodule : asmc_sram_model
`default_nettype wire
